// >>> src/twi_consts.svh
/*
 * Constants shared by both ends of the two-wire pointer link.
 * Assumes inclusion by bare name from files under src/.
 */
`ifndef TWI_CONSTS_SVH
`define TWI_CONSTS_SVH

`define BASE_ADDR       5'h10
`define HS_CODE_TOP     7'h04
`define BIT_LAST        3'h7
`define ACK_LOW         1'b0
// One quarter of an SCL bit; must exceed the slave's filter latency
`define DIV_STEP        8'h20
`define RD_DIR          1'b1
`define WR_DIR          1'b0

`endif

// >>> src/twi_pkg.sv
/*
 * Types shared by both ends of the two-wire pointer link.
 * Assumes twi_consts.svh for the numeric constants.
 */
package twi_pkg;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_RECV  = 3'b001,
		S_RACK  = 3'b010,
		S_SEND  = 3'b011,
		S_TACK  = 3'b100,
		S_SKIP  = 3'b101
	} dev_state_t;

	typedef enum logic [3:0] {
		M_IDLE  = 4'h0,
		M_START = 4'h1,
		M_BITLO = 4'h2,
		M_BITHI = 4'h3,
		M_ACKLO = 4'h4,
		M_ACKHI = 4'h5,
		M_STOP0 = 4'h6,
		M_STOP1 = 4'h7,
		M_STOP2 = 4'h8,
		M_RSTA0 = 4'h9,
		M_RSTA1 = 4'ha
	} mst_state_t;

	typedef enum logic [1:0] {
		B_ADDR  = 2'b00,
		B_PTR   = 2'b01,
		B_DATA  = 2'b10
	} byte_kind_t;

endpackage : twi_pkg

// >>> src/twi_if.sv
/*
 * Two-wire bus carrier: resolves the open-drain SDA and SCL levels from enables.
 * Assumes each party raises its enable only to pull the line low.
 */
`timescale 1ns/1ps
interface twi_if;
	logic scl_oe_m;
	logic sda_oe_m;
	logic sda_oe_d;
	logic scl;
	logic sda;

	// Pull-ups make a released line high
	assign scl = ~scl_oe_m;
	assign sda = ~(sda_oe_m | sda_oe_d);

	modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
	modport device (output sda_oe_d, input scl, input sda);
endinterface : twi_if

// >>> src/line_sync.sv
/*
 * Two-flop synchroniser followed by a majority glitch filter on a bus line.
 * Assumes an asynchronous input and a sampling clock much faster than the line.
 */
`timescale 1ns/1ps
module line_sync (
	input  wire logic clk_i,
	input  wire logic rstn_i,
	input  wire logic line_i,
	output logic      line_o
);
	logic [1:0] meta;
	logic [2:0] hist;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			meta   <= 2'h3;
			hist   <= 3'h7;
			line_o <= 1'b1;
		end else begin
			meta <= {meta[0], line_i};
			hist <= {hist[1:0], meta[1]};
			// Spike shorter than two samples is dropped
			line_o <= (hist[0] & hist[1]) | (hist[1] & hist[2]) | (hist[0] & hist[2]);
		end
	end
endmodule : line_sync

// >>> src/twi_device.sv
/*
 * Slave end of the two-wire pointer link, clocked by the link-side clock.
 * Assumes the interface resolves open-drain levels and the register core answers combinationally.
 */
`timescale 1ns/1ps
`include "twi_consts.svh"
// What this block does
// - First write byte loads the pointer
// - Master sends pointer before data, except on a ptr_only_i read
// - Read returns register at last pointer
// - Pointer-only write then restart read
// - Pointer kept across reads
// - Registers move high byte first
// - Data line released while bus idle
// - SDA fall with SCL high starts
// - SDA rise with SCL high stops
// - Repeated start begins new address
// - No limit on byte count
// - Receiver pulls ninth bit low
// - Master nack ends device sending
// - Master sends high-speed code after start
// - High-speed code unacked, hs_mode_o set; filters unchanged
// - Address byte follows high-speed code
// - High-speed holds until stop
// - Stop clears hs_mode_o back to fast mode
// - Low two address bits come from select pins
// - Device is slave only
// - Seven address bits plus direction, MSB first
module twi_device
	import twi_pkg::*;
(
	input  wire logic   link_clk_i,
	input  wire logic   rstn_i,
	twi_if.device       bus,
	input  wire logic   address_select_pin_hi_i,
	input  wire logic   address_select_pin_lo_i,
	input  wire logic [15:0] rd_data_i,
	output logic [7:0]  pointer_o,
	output logic [15:0] wr_data_o,
	output logic        wr_strobe_o,
	output logic        rd_strobe_o,
	output logic        hs_mode_o
);
	typedef struct packed {
		dev_state_t  st;
		byte_kind_t  kind;
		logic [2:0]  bitn;
		logic [7:0]  shreg;
		logic        rd;
		logic        first;
		logic        hi_half;
		logic [7:0]  hi_byte;
		logic [15:0] tx;
		logic        scl_d;
		logic        sda_d;
		logic        sda_oe;
		logic [7:0]  pointer;
		logic [15:0] wr_data;
		logic        wr_strobe;
		logic        rd_strobe;
		logic        hs;
		logic [1:0]  adr_pins;
		logic        armed;
	} dev_reg_t;

	dev_reg_t r;
	dev_reg_t next_r;
	logic     scl_f;
	logic     sda_f;
	logic     adr_hi_s;
	logic     adr_lo_s;

	line_sync u_scl (.clk_i(link_clk_i), .rstn_i(rstn_i), .line_i(bus.scl), .line_o(scl_f));
	line_sync u_sda (.clk_i(link_clk_i), .rstn_i(rstn_i), .line_i(bus.sda), .line_o(sda_f));
	line_sync u_ah  (.clk_i(link_clk_i), .rstn_i(rstn_i), .line_i(address_select_pin_hi_i),
		.line_o(adr_hi_s));
	line_sync u_al  (.clk_i(link_clk_i), .rstn_i(rstn_i), .line_i(address_select_pin_lo_i),
		.line_o(adr_lo_s));

	function automatic logic addr_match(input logic [6:0] a, input logic [1:0] pins);
		addr_match = (a == {`BASE_ADDR, pins});
	endfunction : addr_match

	logic start_c;
	logic stop_c;
	logic rise_c;
	logic fall_c;

	always_comb begin
		start_c = r.scl_d & scl_f & r.sda_d & ~sda_f;
		stop_c  = r.scl_d & scl_f & ~r.sda_d & sda_f;
		rise_c  = ~r.scl_d & scl_f;
		fall_c  = r.scl_d & ~scl_f;
		next_r = r;
		next_r.scl_d = scl_f;
		next_r.sda_d = sda_f;
		next_r.wr_strobe = 1'b0;
		next_r.rd_strobe = 1'b0;
		next_r.adr_pins = {adr_hi_s, adr_lo_s};
		if (stop_c) begin
			next_r.st = S_IDLE;
			next_r.sda_oe = 1'b0;
			next_r.hs = 1'b0;
		end else if (start_c) begin
			// Repeated start lands here too; high-speed survives it
			next_r.st = S_RECV;
			next_r.kind = B_ADDR;
			next_r.bitn = 3'h0;
			next_r.first = 1'b1;
			next_r.armed = 1'b0;
			next_r.sda_oe = 1'b0;
		end else begin
			unique case (r.st)
				S_IDLE: next_r.sda_oe = 1'b0;
				S_SKIP: next_r.sda_oe = 1'b0;
				S_RECV: begin
					if (rise_c) begin
						next_r.shreg = {r.shreg[6:0], sda_f};
					end
					if (fall_c) begin
						next_r.armed = 1'b1;
					end
					// The fall that closes a START carries no bit
					if (fall_c && r.armed) begin
						next_r.bitn = r.bitn + 3'h1;
						if (r.bitn == `BIT_LAST) begin
							next_r.st = S_RACK;
							next_r.first = 1'b0;
							unique case (r.kind)
								B_ADDR: begin
									if (r.first && r.shreg[7:1] == `HS_CODE_TOP) begin
										next_r.hs = 1'b1;
										next_r.st = S_SKIP;
									end else if (addr_match(r.shreg[7:1], r.adr_pins)) begin
										next_r.sda_oe = 1'b1;
										next_r.rd = r.shreg[0];
									end else begin
										next_r.st = S_SKIP;
									end
								end
								B_PTR: begin
									next_r.pointer = r.shreg;
									next_r.hi_half = 1'b1;
									next_r.sda_oe = 1'b1;
								end
								default: begin
									if (r.hi_half) begin
										next_r.hi_byte = r.shreg;
									end else begin
										next_r.wr_data = {r.hi_byte, r.shreg};
										next_r.wr_strobe = 1'b1;
									end
									next_r.hi_half = ~r.hi_half;
									next_r.sda_oe = 1'b1;
								end
							endcase
						end
					end
				end
				S_RACK: begin
					if (fall_c) begin
						next_r.bitn = 3'h0;
						if (r.kind == B_ADDR && r.rd) begin
							next_r.st = S_SEND;
							next_r.tx = rd_data_i;
							next_r.rd_strobe = 1'b1;
							next_r.hi_half = 1'b1;
							next_r.sda_oe = ~rd_data_i[15];
						end else begin
							next_r.st = S_RECV;
							next_r.kind = (r.kind == B_ADDR) ? B_PTR : B_DATA;
							next_r.sda_oe = 1'b0;
						end
					end
				end
				S_SEND: begin
					if (fall_c) begin
						next_r.bitn = r.bitn + 3'h1;
						if (r.bitn == `BIT_LAST) begin
							next_r.st = S_TACK;
							next_r.sda_oe = 1'b0;
						end else begin
							next_r.tx = {r.tx[14:0], 1'b0};
							next_r.sda_oe = ~r.tx[14];
						end
					end
				end
				S_TACK: begin
					if (rise_c) begin
						if (sda_f != `ACK_LOW) begin
							next_r.st = S_SKIP;
						end
					end
					if (fall_c && r.st == S_TACK) begin
						next_r.st = S_SEND;
						next_r.bitn = 3'h0;
						if (r.hi_half) begin
							next_r.tx = {r.tx[14:0], 1'b0};
							next_r.sda_oe = ~r.tx[14];
						end else begin
							// Reread the same pointer for the next word
							next_r.tx = rd_data_i;
							next_r.rd_strobe = 1'b1;
							next_r.sda_oe = ~rd_data_i[15];
						end
						next_r.hi_half = ~r.hi_half;
					end
				end
				default: next_r.st = S_IDLE;
			endcase
		end
	end

	// Device drives only SDA and never the clock
	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
			r.scl_d <= 1'b1;
			r.sda_d <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign bus.sda_oe_d = r.sda_oe;
	assign pointer_o    = r.pointer;
	assign wr_data_o    = r.wr_data;
	assign wr_strobe_o  = r.wr_strobe;
	assign rd_strobe_o  = r.rd_strobe;
	assign hs_mode_o    = r.hs;
endmodule : twi_device

// >>> src/twi_master.sv
/*
 * Master end of the two-wire pointer link; divides clk_i to make SCL.
 * Assumes one command at a time, accepted only while busy_o is low.
 */
`timescale 1ns/1ps
`include "twi_consts.svh"
module twi_master
	import twi_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	twi_if.master            bus,
	input  wire logic        go_i,
	input  wire logic [6:0]  addr_i,
	input  wire logic        rd_i,
	input  wire logic        hs_i,
	input  wire logic [7:0]  pointer_i,
	input  wire logic        ptr_only_i,
	input  wire logic [15:0] wdata_i,
	input  wire logic [7:0]  nbytes_i,
	output logic             busy_o,
	output logic [15:0]      rdata_o,
	output logic             rvalid_o,
	output logic             nack_o
);
	typedef struct packed {
		mst_state_t  st;
		logic [7:0]  div;
		logic [3:0]  bitn;
		logic [8:0]  shreg;
		logic [7:0]  left;
		logic [1:0]  phase;
		logic        scl_oe;
		logic        sda_oe;
		logic        rd;
		logic        hs_pend;
		logic        recv;
		logic        hi_half;
		logic [15:0] rdata;
		logic        rvalid;
		logic        nack;
		logic        busy;
		logic [1:0]  sda_s;
		logic        up;
		logic        ackb;
	} mst_reg_t;

	mst_reg_t r;
	mst_reg_t next_r;
	logic     tick;

	function automatic logic [7:0] data_byte(input logic [7:0] left, input logic [15:0] w);
		data_byte = left[0] ? w[7:0] : w[15:8];
	endfunction : data_byte

	always_comb begin
		next_r = r;
		next_r.rvalid = 1'b0;
		next_r.sda_s = {r.sda_s[0], bus.sda};
		tick = (r.div == `DIV_STEP);
		next_r.div = tick ? 8'h00 : r.div + 8'h01;
		unique case (r.st)
			M_IDLE: begin
				next_r.div = 8'h00;
				if (go_i) begin
					next_r.busy = 1'b1;
					next_r.st = M_START;
					next_r.up = 1'b0;
					next_r.rd = rd_i;
					next_r.hs_pend = hs_i;
					next_r.left = rd_i ? nbytes_i : (ptr_only_i ? 8'h00 : 8'h02);
					// A read with ptr_only_i skips the pointer and uses the kept one
					next_r.phase = (rd_i && ptr_only_i) ? 2'h2 : 2'h0;
					next_r.nack = 1'b0;
				end
			end
			M_START: if (tick) begin
				next_r.up = ~r.up;
				if (!r.up) begin
					next_r.sda_oe = 1'b1;
				end else begin
					next_r.scl_oe = 1'b1;
					next_r.st = M_BITLO;
					next_r.bitn = 4'h0;
					next_r.recv = 1'b0;
					next_r.hi_half = 1'b1;
					next_r.shreg = r.hs_pend ? {`HS_CODE_TOP, 1'b0, 1'b1}
						: {addr_i, (r.phase == 2'h2) ? `RD_DIR : `WR_DIR, 1'b1};
				end
			end
			// Data moves a quarter after SCL falls, so it never changes under a high clock
			M_BITLO: if (tick) begin
				next_r.up = ~r.up;
				if (!r.up) begin
					if (r.recv) begin
						next_r.sda_oe = (r.bitn == 4'h8) ? (r.left != 8'h01) : 1'b0;
					end else begin
						next_r.sda_oe = ~r.shreg[8];
					end
				end else begin
					next_r.scl_oe = 1'b0;
					next_r.st = M_BITHI;
				end
			end
			M_BITHI: if (tick) begin
				next_r.up = ~r.up;
				if (!r.up) begin
					if (r.bitn == 4'h8) begin
						next_r.ackb = r.sda_s[1];
					end else if (r.recv) begin
						next_r.shreg = {r.shreg[7:0], r.sda_s[1]};
					end
				end else begin
					next_r.scl_oe = 1'b1;
					next_r.bitn = r.bitn + 4'h1;
					next_r.st = (r.bitn == 4'h8) ? M_ACKHI : M_BITLO;
					if (!r.recv) begin
						next_r.shreg = {r.shreg[7:0], 1'b1};
					end
				end
			end
			// Byte finished, SCL is low: pick what follows
			M_ACKHI: begin
				next_r.bitn = 4'h0;
				next_r.sda_oe = 1'b0;
				next_r.st = M_BITLO;
				if (r.recv) begin
					next_r.hi_half = ~r.hi_half;
					if (r.hi_half) begin
						next_r.rdata[15:8] = r.shreg[7:0];
					end else begin
						next_r.rdata[7:0] = r.shreg[7:0];
						next_r.rvalid = 1'b1;
					end
					next_r.left = r.left - 8'h01;
					if (r.left == 8'h01) begin
						next_r.st = M_STOP0;
					end
				end else if (r.hs_pend) begin
					// Code byte is never acknowledged; restart with the same SCL divider
					next_r.hs_pend = 1'b0;
					next_r.st = M_RSTA0;
				end else if (r.ackb != `ACK_LOW) begin
					next_r.nack = 1'b1;
					next_r.st = M_STOP0;
				end else if (r.phase == 2'h0) begin
					next_r.phase = 2'h1;
					next_r.shreg = {pointer_i, 1'b1};
					if (r.rd) begin
						next_r.left = 8'h00;
					end
				end else if (r.phase == 2'h2) begin
					next_r.recv = 1'b1;
				end else if (r.left == 8'h00) begin
					next_r.st = r.rd ? M_RSTA0 : M_STOP0;
					if (r.rd) begin
						next_r.phase = 2'h2;
						next_r.left = nbytes_i;
					end
				end else begin
					next_r.shreg = {data_byte(r.left, wdata_i), 1'b1};
					next_r.left = r.left - 8'h01;
				end
			end
			M_RSTA0: if (tick) begin
				next_r.sda_oe = 1'b0;
				next_r.st = M_RSTA1;
			end
			M_RSTA1: if (tick) begin
				next_r.scl_oe = 1'b0;
				next_r.up = 1'b0;
				next_r.st = M_START;
			end
			M_STOP0: if (tick) begin
				next_r.sda_oe = 1'b1;
				next_r.st = M_STOP1;
			end
			M_STOP1: if (tick) begin
				next_r.scl_oe = 1'b0;
				next_r.st = M_STOP2;
			end
			M_STOP2: if (tick) begin
				next_r.sda_oe = 1'b0;
				next_r.busy = 1'b0;
				next_r.st = M_IDLE;
			end
			default: next_r.st = M_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
			r.sda_s <= 2'h3;
		end else begin
			r <= next_r;
		end
	end

	assign bus.scl_oe_m = r.scl_oe;
	assign bus.sda_oe_m = r.sda_oe;
	assign busy_o   = r.busy;
	assign rdata_o  = r.rdata;
	assign rvalid_o = r.rvalid;
	assign nack_o   = r.nack;
endmodule : twi_master

// >>> tb/twi_properties.sv
/*
 * Bus-level assertions for the two-wire pointer link.
 * Assumes it sits beside twi_if; scl is made from clk_i, so clk_i samples it cleanly.
 */
`timescale 1ns/1ps
`include "twi_consts.svh"
module twi_properties (
	input  wire logic	clk_i,
	input  wire logic	link_clk_i,
	input  wire logic	rstn_i,
	input  wire logic	address_select_pin_hi_i,
	input  wire logic	address_select_pin_lo_i,
	input  wire logic	sda_oe_d,
	input  wire logic	scl,
	input  wire logic	sda
);
	logic		scl_q;
	logic		sda_q;
	logic		busy;
	logic		adr;
	logic		rd;
	logic		mute;
	logic [3:0]	nbit;
	logic [7:0]	sh;
	logic [6:0]	own;
	logic		rise;
	logic		ack;

	assign own = {`BASE_ADDR, address_select_pin_hi_i, address_select_pin_lo_i};
	assign rise = scl && !scl_q && busy;
	assign ack = rise && nbit == 4'h8;

	// Bus tracker; mute marks a span where the device has no business on the line
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			busy <= 1'b0;
			adr <= 1'b0;
			rd <= 1'b0;
			mute <= 1'b0;
			nbit <= 4'h0;
			sh <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (scl && scl_q && sda_q && !sda) begin
				busy <= 1'b1;
				adr <= 1'b1;
				mute <= 1'b0;
				nbit <= 4'h0;
			end else if (scl && scl_q && !sda_q && sda) begin
				busy <= 1'b0;
				adr <= 1'b0;
				mute <= 1'b0;
			end else if (ack) begin
				nbit <= 4'h0;
				adr <= sh[7:1] == `HS_CODE_TOP;
				if (adr)
					rd <= sh[0];
				if (adr && sh[7:1] != own && sh[7:1] != `HS_CODE_TOP)
					mute <= 1'b1;
				if (!adr && rd && sda)
					mute <= 1'b1;
			end else if (rise) begin
				nbit <= nbit + 4'h1;
				sh <= {sh[6:0], sda};
			end
		end
	end

	a_idle_released: assert property (@(posedge clk_i) disable iff (!rstn_i)
		!busy |-> !sda_oe_d) else $error("device pulls data line on idle bus");
	a_addr_acked: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ack && adr && sh[7:1] == own |-> (sda_oe_d && !sda)[*8])
		else $error("own address not acknowledged");
	a_hs_unacked: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ack && adr && sh[7:1] == `HS_CODE_TOP |-> !sda_oe_d[*8])
		else $error("high-speed code acknowledged");
	a_write_acked: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ack && !adr && !rd && !mute |-> sda_oe_d[*8]) else $error("written byte not acknowledged");
	a_read_no_ack: assert property (@(posedge clk_i) disable iff (!rstn_i)
		ack && !adr && rd |-> !sda_oe_d) else $error("device drives master acknowledge slot");
	a_quiet_after: assert property (@(posedge clk_i) disable iff (!rstn_i)
		mute |-> !sda_oe_d) else $error("device drives line after nack or mismatch");
	a_addr_bits_free: assert property (@(posedge clk_i) disable iff (!rstn_i)
		rise && adr && nbit != 4'h8 |-> !sda_oe_d) else $error("device drives during address");
	a_ack_steady: assert property (@(posedge link_clk_i) disable iff (!rstn_i)
		scl && $past(scl) |-> $stable(sda_oe_d)) else $error("device data changes while clock high");
endmodule : twi_properties

// >>> tb/two_wire_pointer_slave_tb.sv
/*
 * Testbench joining the master and device ends over one twi_if.
 * Assumes the register core answers {pointer, ~pointer} for any pointer.
 */
`timescale 1ns/1ps
module two_wire_pointer_slave_tb;
	logic		clk_i;
	logic		link_clk_i;
	logic		rstn_i;
	logic		go_i;
	logic		rd_i;
	logic		hs_i;
	logic		ptr_only_i;
	logic		pin_hi;
	logic		pin_lo;
	logic [6:0]	addr_i;
	logic [7:0]	pointer_i;
	logic [7:0]	nbytes_i;
	logic [7:0]	pointer_o;
	logic [15:0]	wdata_i;
	logic [15:0]	rdata_o;
	logic [15:0]	wr_data_o;
	logic [15:0]	rd_data_i;
	logic		busy_o;
	logic		rvalid_o;
	logic		nack_o;
	logic		wr_strobe_o;
	logic		hs_mode_o;
	logic		hs_seen;
	int		err_total = 0;
	int		n_tests = 0;
	int		n_wr = 0;
	int		n_rv = 0;

	twi_if twi_if_i();
	twi_master twi_master_i (.clk_i(clk_i), .rstn_i(rstn_i), .bus(twi_if_i), .go_i(go_i),
		.addr_i(addr_i), .rd_i(rd_i), .hs_i(hs_i), .pointer_i(pointer_i),
		.ptr_only_i(ptr_only_i), .wdata_i(wdata_i), .nbytes_i(nbytes_i), .busy_o(busy_o),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .nack_o(nack_o));
	twi_device twi_device_i (.link_clk_i(link_clk_i), .rstn_i(rstn_i), .bus(twi_if_i),
		.address_select_pin_hi_i(pin_hi), .address_select_pin_lo_i(pin_lo),
		.rd_data_i(rd_data_i), .pointer_o(pointer_o), .wr_data_o(wr_data_o),
		.wr_strobe_o(wr_strobe_o), .rd_strobe_o(), .hs_mode_o(hs_mode_o));
	twi_properties twi_properties_i (.clk_i(clk_i), .link_clk_i(link_clk_i), .rstn_i(rstn_i),
		.address_select_pin_hi_i(pin_hi), .address_select_pin_lo_i(pin_lo),
		.sda_oe_d(twi_if_i.sda_oe_d), .scl(twi_if_i.scl), .sda(twi_if_i.sda));

	assign rd_data_i = {pointer_o, ~pointer_o};

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// Odd offset keeps the link clock out of step with clk_i
	initial begin
		link_clk_i = 1'b0;
		#7;
		forever #32 link_clk_i = ~link_clk_i;
	end
	always @(posedge link_clk_i) begin
		if (wr_strobe_o === 1'b1)
			n_wr++;
		if (hs_mode_o === 1'b1)
			hs_seen = 1'b1;
	end
	always @(posedge clk_i) begin
		if (rvalid_o === 1'b1)
			n_rv++;
	end

	task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
			err_total++;
		end
	endtask : check

	task run(input logic [6:0] a, input logic r, input logic h, input logic po,
		input logic [7:0] p, input logic [15:0] w, input logic [7:0] n);
		int k;
		@(negedge clk_i);
		addr_i = a;
		rd_i = r;
		hs_i = h;
		ptr_only_i = po;
		pointer_i = p;
		wdata_i = w;
		nbytes_i = n;
		go_i = 1'b1;
		@(negedge clk_i);
		go_i = 1'b0;
		k = 0;
		while (busy_o !== 1'b0 && k < 20000) begin
			@(negedge clk_i);
			k++;
		end
		check("busy_o", 16'(busy_o), 16'h0000);
		// Device strobes land a few link clocks late
		repeat (16) @(negedge clk_i);
	endtask : run

	task t_write;
		int w0;
		w0 = n_wr;
		run(7'h40, 1'b0, 1'b0, 1'b0, 8'h02, 16'ha5c3, 8'h02);
		check("nack_o", 16'(nack_o), 16'h0000);
		check("pointer_o", 16'(pointer_o), 16'h0002);
		check("wr_data_o", wr_data_o, 16'ha5c3);
		check("wr_strobes", 16'(n_wr - w0), 16'h0001);
	endtask : t_write

	task t_ptr_read;
		int w0;
		int v0;
		w0 = n_wr;
		run(7'h40, 1'b0, 1'b0, 1'b1, 8'h7e, 16'h0000, 8'h02);
		check("pointer_o", 16'(pointer_o), 16'h007e);
		check("wr_strobes", 16'(n_wr - w0), 16'h0000);
		v0 = n_rv;
		run(7'h40, 1'b1, 1'b0, 1'b0, 8'h7e, 16'h0000, 8'h02);
		check("rdata_o", rdata_o, 16'h7e81);
		check("rvalids", 16'(n_rv - v0), 16'h0001);
	endtask : t_ptr_read

	task t_long_read;
		int v0;
		v0 = n_rv;
		// No pointer byte here: the word must come from the kept pointer
		run(7'h40, 1'b1, 1'b0, 1'b1, 8'h00, 16'h0000, 8'h06);
		check("rdata_o", rdata_o, 16'h7e81);
		check("rvalids", 16'(n_rv - v0), 16'h0003);
		check("pointer_o", 16'(pointer_o), 16'h007e);
	endtask : t_long_read

	task t_wrong;
		int w0;
		w0 = n_wr;
		run(7'h41, 1'b0, 1'b0, 1'b0, 8'h55, 16'hffff, 8'h02);
		check("nack_o", 16'(nack_o), 16'h0001);
		check("pointer_o", 16'(pointer_o), 16'h007e);
		check("wr_strobes", 16'(n_wr - w0), 16'h0000);
	endtask : t_wrong

	task t_hs;
		hs_seen = 1'b0;
		run(7'h40, 1'b0, 1'b1, 1'b0, 8'h03, 16'h1234, 8'h02);
		check("hs_seen", 16'(hs_seen), 16'h0001);
		check("hs_mode_o", 16'(hs_mode_o), 16'h0000);
		check("wr_data_o", wr_data_o, 16'h1234);
		check("pointer_o", 16'(pointer_o), 16'h0003);
	endtask : t_hs

	task t_pins;
		@(negedge clk_i);
		pin_hi = 1'b1;
		pin_lo = 1'b1;
		run(7'h43, 1'b0, 1'b0, 1'b0, 8'h04, 16'h0ff0, 8'h02);
		check("nack_o", 16'(nack_o), 16'h0000);
		check("pointer_o", 16'(pointer_o), 16'h0004);
		run(7'h40, 1'b0, 1'b0, 1'b0, 8'h09, 16'h0ff0, 8'h02);
		check("nack_o", 16'(nack_o), 16'h0001);
		pin_hi = 1'b0;
		pin_lo = 1'b0;
	endtask : t_pins

	task summarize;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	initial begin
		rstn_i = 1'b0;
		go_i = 1'b0;
		rd_i = 1'b0;
		hs_i = 1'b0;
		ptr_only_i = 1'b0;
		pin_hi = 1'b0;
		pin_lo = 1'b0;
		addr_i = 7'h00;
		pointer_i = 8'h00;
		wdata_i = 16'h0000;
		nbytes_i = 8'h00;
		hs_seen = 1'b0;
		repeat (5) @(negedge clk_i);
		rstn_i = 1'b1;
		// Give the device filters time to settle
		repeat (24) @(negedge clk_i);
		t_write;
		t_ptr_read;
		t_long_read;
		t_wrong;
		t_hs;
		t_pins;
		check("scl", 16'(twi_if_i.scl), 16'h0001);
		check("sda", 16'(twi_if_i.sda), 16'h0001);
		summarize;
	end

	initial begin
		#1500us;
		err_total++;
		summarize;
	end
endmodule : two_wire_pointer_slave_tb
